/* dv/ptp_timer_pair_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module ptp_timer_pair_tb_top;
   import ptp_pkg::*;

   logic        clk_i;
   logic        rst_i;
   logic        wb_cyc;
   logic        wb_stb;
   logic        wb_we;
   logic [7:0]  wb_adr;
   logic [3:0]  wb_sel;
   logic [31:0] wb_wdat;
   logic [31:0] wb_rdat;
   logic        wb_ack;
   logic        ext_cnt = 1'h0;
   logic        pin;
   int          error_cnt;
   int          n_checks;
   int          tap [4] = '{2, 8, 32, 128};

   ptp_timer_pair dut_u (
      .clk_i              (clk_i),
      .rst_i              (rst_i),
      .wb_cyc_i           (wb_cyc),
      .wb_stb_i           (wb_stb),
      .wb_we_i            (wb_we),
      .wb_adr_i           (wb_adr),
      .wb_sel_i           (wb_sel),
      .wb_dat_i           (wb_wdat),
      .wb_dat_o           (wb_rdat),
      .wb_ack_o           (wb_ack),
      .ext_count_i        (ext_cnt),
      .timer_output_pin_o (pin)
   );

   initial begin
      clk_i = 1'h0;
      forever #10 clk_i = ~clk_i;
   end

   // External count: one rising edge every two clocks
   always @(posedge clk_i) begin
      ext_cnt <= ~ext_cnt;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic end_of_test;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic hang;
      error_cnt++;
      $display("mismatch wait expected done seen timeout");
      end_of_test();
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %0h seen %0h", nm, exp, got);
      end
   endtask

   // Classic single cycle; holds everything until ack is sampled high
   task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                          output logic [31:0] q);
      int i;
      @(posedge clk_i);
      wb_cyc  <= 1'h1;
      wb_stb  <= 1'h1;
      wb_we   <= w;
      wb_adr  <= a;
      wb_wdat <= {24'h0, d};
      wb_sel  <= 4'hF;
      for (i = 0; i < 20; i++) begin
         @(posedge clk_i);
         if (wb_ack === 1'h1) break;
      end
      if (i == 20) hang();
      q = wb_rdat;
      wb_cyc <= 1'h0;
      wb_stb <= 1'h0;
      wb_we  <= 1'h0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      wb_xfer(1'h1, a, d, q);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
      logic [31:0] q;
      wb_xfer(1'h0, a, 8'h0, q);
      chk(nm, exp, q);
   endtask

   // Flop action written before the compares so the compare regs load directly
   task automatic setup(input logic [7:0] md, input logic [7:0] c1, input logic [7:0] c2,
                        input logic [7:0] fc);
      wr(OFS_RUN_CONTROL, 8'h00);
      wr(OFS_FLOP_CONTROL, fc);
      wr(OFS_FIRST_CMP, c1);
      wr(OFS_SECOND_CMP, c2);
      wr(OFS_PAIR_MODE, md);
      wr(OFS_RUN_CONTROL, 8'h83);
   endtask

   task automatic wait_lvl(input logic lvl, output int n);
      n = 0;
      while (pin !== lvl) begin
         @(posedge clk_i);
         #1;
         n++;
         if (n > 5000) hang();
      end
   endtask

   // A full fall is passed first so any buffered reload has landed
   task automatic pulse(input int hi, input int lo);
      int n;
      int h;
      int l;
      wait_lvl(1'h1, n);
      wait_lvl(1'h0, n);
      wait_lvl(1'h1, n);
      wait_lvl(1'h0, h);
      wait_lvl(1'h1, l);
      chk("high cycles", hi, h);
      chk("low cycles", lo, l);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      int s;
      int p;
      int top;
      logic [31:0] q1;
      logic [31:0] q2;
      rst_i   = 1'h1;
      wb_cyc  = 1'h0;
      wb_stb  = 1'h0;
      wb_we   = 1'h0;
      wb_adr  = 8'h00;
      wb_sel  = 4'h0;
      wb_wdat = 32'h0;
      error_cnt = 0;
      n_checks  = 0;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'h0;
      rd(OFS_STATUS, 32'h0, "status");
      rd(8'h18, 32'h0, "unmapped");
      // Dual mode: lower match every 16 clocks, upper match on every second one
      for (s = 0; s < 2; s++) begin
         setup({PAIR_DUAL8, 2'h0, 2'h0, 2'h1}, 8'h01, 8'h01, 8'h4A | s[7:0]);
         pulse(16 << s, 16 << s);
      end
      // Cascade: 16-bit compare 0x0102 gives 259 pin-clocked ticks per toggle
      setup({PAIR_CASC16, 2'h0, 2'h0, 2'h0}, 8'h02, 8'h01, 8'h4A);
      pulse(518, 518);
      for (s = 0; s < 4; s++) begin
         setup({PAIR_PPG, 2'h0, 2'h1, s[1:0]}, 8'h01, 8'h02, 8'h4A);
         pulse(tap[s], 2 * tap[s]);
      end
      setup({PAIR_PPG, 2'h0, 2'h1, 2'h1}, 8'h01, 8'h02, 8'h46);
      pulse(16, 8);
      rd(OFS_FLOP_CONTROL, 32'h4E, "flop control");
      setup({PAIR_PPG, 2'h0, 2'h1, 2'h1}, 8'h01, 8'h04, 8'h4A);
      pulse(24, 16);
      wr(OFS_FLOP_CONTROL, 8'hCE);
      wr(OFS_FIRST_CMP, 8'h03);
      rd(OFS_FIRST_CMP, 32'h3, "first buffer");
      pulse(8, 32);
      for (p = 1; p < 4; p++) begin
         top = (1 << (5 + p)) - 1;
         setup({PAIR_PWM, p[1:0], 2'h1, 2'h1}, 8'h10, 8'hFF, 8'h4A);
         pulse((top - 16) * 8, 136);
      end
      // Upper timer keeps counting beside the PWM; samples 32 clocks apart see four ticks
      wb_xfer(1'h0, OFS_STATUS, 8'h0, q1);
      repeat (29) @(posedge clk_i);
      wb_xfer(1'h0, OFS_STATUS, 8'h0, q2);
      chk("upper moved", 32'h4, {24'h0, q2[15:8] - q1[15:8]});
      setup({PAIR_PWM, 2'h1, 2'h1, 2'h1}, 8'h10, 8'hFF, 8'h4A);
      wr(OFS_FLOP_CONTROL, 8'hCE);
      wr(OFS_FIRST_CMP, 8'h30);
      pulse(120, 392);
      wr(OFS_FLOP_CONTROL, 8'h0E);
      repeat (2) @(posedge clk_i);
      p = 0;
      for (s = 0; s < 600; s++) begin
         @(posedge clk_i);
         #1;
         if (pin !== 1'h0) p++;
      end
      chk("pin disabled", 32'h0, p);
      end_of_test();
   end

endmodule

`default_nettype wire

/* src/ptp_counter8.sv */
`timescale 1ns/1ps
`default_nettype none

module ptp_counter8 (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       run_i,
   input  wire logic       inc_i,
   input  wire logic       clr_i,
   output logic [7:0]      count_o
);
   import ptp_pkg::*;

   typedef struct packed {
      logic [7:0] cnt;
   } ptp_cnt_state_type;

   ptp_cnt_state_type st_r;
   ptp_cnt_state_type st_nxt;

   // Stopping also clears, so a restart always begins at zero
   always_comb begin
      st_nxt = st_r;
      if (!run_i || clr_i) begin
         st_nxt.cnt = CNT_RESET;
      end else if (inc_i) begin
         st_nxt.cnt = st_r.cnt + 8'h01;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign count_o = st_r.cnt;

endmodule

`default_nettype wire

/* src/ptp_pkg.sv */
`default_nettype none

package ptp_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register byte offsets on the Wishbone slave
   localparam logic [7:0] OFS_RUN_CONTROL  = 8'h00;
   localparam logic [7:0] OFS_PAIR_MODE    = 8'h04;
   localparam logic [7:0] OFS_FLOP_CONTROL = 8'h08;
   localparam logic [7:0] OFS_FIRST_CMP    = 8'h0C;
   localparam logic [7:0] OFS_SECOND_CMP   = 8'h10;
   localparam logic [7:0] OFS_STATUS       = 8'h14;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int RUN_LOWER_BIT   = 0;
   localparam int RUN_UPPER_BIT   = 1;
   localparam int RUN_PRESC_BIT   = 7;
   localparam int MODE_LO_CLK_LSB = 0;
   localparam int MODE_UP_CLK_LSB = 2;
   localparam int MODE_PERIOD_LSB = 4;
   localparam int MODE_PAIR_LSB   = 6;
   localparam int FC_SOURCE_BIT   = 0;
   localparam int FC_TOG_EN_BIT   = 1;
   localparam int FC_CODE_LSB     = 2;
   localparam int FC_PIN_EN_BIT   = 6;
   localparam int FC_DOUBLE_BUFFER_ENABLE_BIT     = 7;
   localparam int ST_UPPER_LSB    = 8;
   localparam int ST_FLOP_BIT     = 16;

   ////////////////////////////////////////////////////////////////////////////
   // Encodings
   localparam logic [1:0] PAIR_DUAL8   = 2'h0;
   localparam logic [1:0] PAIR_CASC16  = 2'h1;
   localparam logic [1:0] PAIR_PPG     = 2'h2;
   localparam logic [1:0] PAIR_PWM     = 2'h3;
   localparam logic [1:0] FLOP_INVERT  = 2'h0;
   localparam logic [1:0] FLOP_SET     = 2'h1;
   localparam logic [1:0] FLOP_CLEAR   = 2'h2;
   localparam logic [1:0] FLOP_KEEP    = 2'h3;
   localparam logic [1:0] PERIOD_6BIT  = 2'h1;
   localparam logic [1:0] PERIOD_7BIT  = 2'h2;
   localparam logic [7:0] TOP_6BIT     = 8'h3F;
   localparam logic [7:0] TOP_7BIT     = 8'h7F;
   localparam logic [7:0] TOP_8BIT     = 8'hFF;

   ////////////////////////////////////////////////////////////////////////////
   // Prescaler taps: a tap fires when all its low bits are one
   localparam logic [10:0] TAP_8_MASK    = 11'h007;
   localparam logic [10:0] TAP_32_MASK   = 11'h01F;
   localparam logic [10:0] TAP_128_MASK  = 11'h07F;
   localparam logic [10:0] TAP_2048_MASK = 11'h7FF;

   localparam logic [7:0]  CNT_RESET  = 8'h00;
   localparam logic [31:0] DATA_ZERO  = 32'h0000_0000;

endpackage

`default_nettype wire

/* src/ptp_timer_pair.sv */
// Function
// RULE1: Pulse mode toggles the flop at first-compare match and again at second-compare match.
// RULE2: Pulse mode clears the lower counter when it matches the second compare.
// RULE3: Software keeps first compare below second compare in pulse mode.
// RULE4: Software sets the upper run bit in pulse mode; upper timer unavailable.
// RULE5: Pulse mode with double buffering reloads first compare at second-compare match.
// RULE6: Software picks pulse polarity by clearing or setting the flop first.
// RULE7: PWM uses only the lower timer; upper timer stays an independent 8-bit timer.
// RULE8: PWM toggles the flop at first-compare match and at 2^n-1 overflow.
// RULE9: PWM clears the lower counter at each 2^n-1 overflow.
// RULE10: Software keeps PWM first compare nonzero and below the overflow value.
// RULE11: PWM with double buffering reloads first compare at each overflow.
// RULE12: Pair mode 00 dual 8-bit, 01 cascaded 16-bit, 10 pulse generation.
// RULE13: Pair mode 11 is PWM; period 01, 10, 11 give 2^6-1, 2^7-1, 2^8-1.
// RULE14: Lower clock select 00 pin, 01 8/fc, 10 32/fc, 11 128/fc.
// RULE15: Upper clock select 01 8/fc, 10 128/fc, 11 2048/fc; 00 lower match in dual.
// RULE16: Dual mode flop source picks lower or upper match; upper output off beside PWM.
// RULE17: The flop drives the timer output pin when the pin function is selected.
//
// Register access over Wishbone and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module ptp_timer_pair (
   input  wire logic                clk_i,
   input  wire logic                rst_i,
   input  wire logic                wb_cyc_i,
   input  wire logic                wb_stb_i,
   input  wire logic                wb_we_i,
   input  wire logic [7:0]          wb_adr_i,
   input  wire logic [3:0]          wb_sel_i,
   input  wire logic [31:0]         wb_dat_i,
   output logic      [31:0]         wb_dat_o,
   output logic                     wb_ack_o,
   input  wire logic                ext_count_i,
   output logic                     timer_output_pin_o
);
   import ptp_pkg::*;

   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
      logic        run_lo;
      logic        run_up;
      logic        run_pre;
      logic [1:0]  lower_clock_select;
      logic [1:0]  upper_clock_select;
      logic [1:0]  pwm_period_field;
      logic [1:0]  pair_mode_field;
      logic        flop_toggle_source;
      logic        tog_en;
      logic        pin_en;
      logic        double_buffer_enable;
      logic [7:0]  first_compare_reg;
      logic [7:0]  cmp_buffer;
      logic [7:0]  second_compare_reg;
      logic [10:0] presc;
      logic        ext_prev;
      logic        output_toggle_flop;
      logic        pin;
   } ptp_state_type;

   ptp_state_type st_r;
   ptp_state_type st_nxt;

   logic [7:0] lower_up_counter;
   logic [7:0] upper_up_counter;
   logic       lo_inc;
   logic       lo_clr;
   logic       up_inc;
   logic       up_clr;
   logic       lo_tick;
   logic       up_tick;
   logic       ext_edge;
   logic       tap8;
   logic       tap32;
   logic       tap128;
   logic       tap2048;
   logic       lo_m1;
   logic       lo_m2;
   logic       up_m;
   logic       ovf;
   logic       joint;
   logic       tog;
   logic       load;
   logic [7:0] top;
   logic       req;
   logic       wr_hit;
   logic       flop_wr;

   ////////////////////////////////////////////////////////////////////////////
   // Counters
   ptp_counter8 u_lower (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .run_i   (st_r.run_lo),
      .inc_i   (lo_inc),
      .clr_i   (lo_clr),
      .count_o (lower_up_counter)
   );
   ptp_counter8 u_upper (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .run_i   (st_r.run_up),
      .inc_i   (up_inc),
      .clr_i   (up_clr),
      .count_o (upper_up_counter)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Clock sources and compare events
   always_comb begin
      ext_edge = ext_count_i & ~st_r.ext_prev;
      tap8     = st_r.run_pre && ((st_r.presc & TAP_8_MASK) == TAP_8_MASK);
      tap32    = st_r.run_pre && ((st_r.presc & TAP_32_MASK) == TAP_32_MASK);
      tap128   = st_r.run_pre && ((st_r.presc & TAP_128_MASK) == TAP_128_MASK);
      tap2048  = st_r.run_pre && ((st_r.presc & TAP_2048_MASK) == TAP_2048_MASK);
      unique case (st_r.lower_clock_select)                               // RULE14
         2'h0: lo_tick = ext_edge;
         2'h1: lo_tick = tap8;
         2'h2: lo_tick = tap32;
         2'h3: lo_tick = tap128;
      endcase
      unique case (st_r.pwm_period_field)                                  // RULE13
         PERIOD_6BIT: top = TOP_6BIT;
         PERIOD_7BIT: top = TOP_7BIT;
         default:     top = TOP_8BIT;
      endcase
      lo_m1 = lo_tick && (lower_up_counter == st_r.first_compare_reg);
      lo_m2 = lo_tick && (lower_up_counter == st_r.second_compare_reg);
      ovf   = lo_tick && (lower_up_counter == top);
      joint = lo_m1 && (upper_up_counter == st_r.second_compare_reg);
      lo_inc = lo_tick;
      lo_clr = 1'b0;
      up_clr = 1'b0;
      up_inc = 1'b0;
      up_tick = 1'b0;
      up_m   = 1'b0;
      tog    = 1'b0;
      load   = 1'b0;
      unique case (st_r.pair_mode_field)                                   // RULE12
         PAIR_DUAL8: begin
            unique case (st_r.upper_clock_select)                          // RULE15
               2'h0: up_tick = lo_m1;
               2'h1: up_tick = tap8;
               2'h2: up_tick = tap128;
               2'h3: up_tick = tap2048;
            endcase
            up_m   = up_tick && (upper_up_counter == st_r.second_compare_reg);
            lo_clr = lo_m1;
            up_inc = up_tick;
            up_clr = up_m;
            tog    = st_r.flop_toggle_source ? up_m : lo_m1;               // RULE16
         end
         PAIR_CASC16: begin
            // Lower match alone never clears; both halves clear together
            up_inc = lo_tick && (lower_up_counter == TOP_8BIT) && !joint;
            lo_clr = joint;
            up_clr = joint;
            tog    = joint;
         end
         PAIR_PPG: begin
            // Upper counter is held at zero, it has no job here
            lo_clr = lo_m2;                                                // RULE2
            up_clr = 1'b1;
            tog    = lo_m1 ^ lo_m2;                                        // RULE1
            load   = lo_m2;                                                // RULE5
         end
         PAIR_PWM: begin
            unique case (st_r.upper_clock_select)                          // RULE15
               2'h0: up_tick = 1'b0;
               2'h1: up_tick = tap8;
               2'h2: up_tick = tap128;
               2'h3: up_tick = tap2048;
            endcase
            up_m   = up_tick && (upper_up_counter == st_r.second_compare_reg);
            up_inc = up_tick;                                              // RULE7
            up_clr = up_m;
            lo_clr = ovf;                                                  // RULE9
            tog    = lo_m1 ^ ovf;                                          // RULE8 RULE16
            load   = ovf;                                                  // RULE11
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Wishbone slave, registers and output flop
   assign req     = wb_cyc_i && wb_stb_i;
   assign wr_hit  = req && wb_we_i && st_r.ack && wb_sel_i[0];
   assign flop_wr = wr_hit && (wb_adr_i == OFS_FLOP_CONTROL);
   always_comb begin
      st_nxt          = st_r;
      st_nxt.ext_prev = ext_count_i;
      st_nxt.presc    = st_r.run_pre ? st_r.presc + 11'h001 : 11'h000;
      // A same-cycle first compare write only reaches the buffer, so the reload still takes the old buffer value
      if (st_r.double_buffer_enable && load) begin
         st_nxt.first_compare_reg = st_r.cmp_buffer;                       // RULE5 RULE11
      end
      if (st_r.tog_en && tog) begin
         st_nxt.output_toggle_flop = ~st_r.output_toggle_flop;             // RULE1 RULE8
      end
      if (wr_hit) begin
         unique case (wb_adr_i)
            OFS_RUN_CONTROL: begin
               st_nxt.run_lo  = wb_dat_i[RUN_LOWER_BIT];
               st_nxt.run_up  = wb_dat_i[RUN_UPPER_BIT];                   // RULE4
               st_nxt.run_pre = wb_dat_i[RUN_PRESC_BIT];
            end
            OFS_PAIR_MODE: begin
               st_nxt.lower_clock_select = wb_dat_i[MODE_LO_CLK_LSB +: 2];
               st_nxt.upper_clock_select = wb_dat_i[MODE_UP_CLK_LSB +: 2];
               st_nxt.pwm_period_field   = wb_dat_i[MODE_PERIOD_LSB +: 2];
               st_nxt.pair_mode_field    = wb_dat_i[MODE_PAIR_LSB +: 2];
            end
            OFS_FLOP_CONTROL: begin
               st_nxt.flop_toggle_source   = wb_dat_i[FC_SOURCE_BIT];
               st_nxt.tog_en               = wb_dat_i[FC_TOG_EN_BIT];
               st_nxt.pin_en               = wb_dat_i[FC_PIN_EN_BIT];
               st_nxt.double_buffer_enable = wb_dat_i[FC_DOUBLE_BUFFER_ENABLE_BIT];
               // Software invert, set or clear overrides a hardware toggle; keep lets the toggle land
               unique case (wb_dat_i[FC_CODE_LSB +: 2])                    // RULE6
                  FLOP_INVERT: st_nxt.output_toggle_flop = ~st_r.output_toggle_flop;
                  FLOP_SET:    st_nxt.output_toggle_flop = 1'b1;
                  FLOP_CLEAR:  st_nxt.output_toggle_flop = 1'b0;
                  FLOP_KEEP:   st_nxt.output_toggle_flop = st_nxt.output_toggle_flop;
               endcase
            end
            OFS_FIRST_CMP: begin
               st_nxt.cmp_buffer = wb_dat_i[7:0];
               if (!st_r.double_buffer_enable) begin
                  st_nxt.first_compare_reg = wb_dat_i[7:0];
               end
            end
            OFS_SECOND_CMP: begin
               st_nxt.second_compare_reg = wb_dat_i[7:0];
            end
            default: ;
         endcase
      end
      st_nxt.ack = req && !st_r.ack;
      st_nxt.dat = DATA_ZERO;
      if (req && !st_r.ack && !wb_we_i) begin
         unique case (wb_adr_i)
            OFS_RUN_CONTROL: begin
               st_nxt.dat[RUN_LOWER_BIT] = st_r.run_lo;
               st_nxt.dat[RUN_UPPER_BIT] = st_r.run_up;
               st_nxt.dat[RUN_PRESC_BIT] = st_r.run_pre;
            end
            OFS_PAIR_MODE: begin
               st_nxt.dat[7:0] = {st_r.pair_mode_field, st_r.pwm_period_field,
                                  st_r.upper_clock_select, st_r.lower_clock_select};
            end
            OFS_FLOP_CONTROL: begin
               // The action code reads as "keep" since it is a command
               st_nxt.dat[FC_SOURCE_BIT]      = st_r.flop_toggle_source;
               st_nxt.dat[FC_TOG_EN_BIT]      = st_r.tog_en;
               st_nxt.dat[FC_CODE_LSB +: 2]   = FLOP_KEEP;
               st_nxt.dat[FC_PIN_EN_BIT]      = st_r.pin_en;
               st_nxt.dat[FC_DOUBLE_BUFFER_ENABLE_BIT]        = st_r.double_buffer_enable;
            end
            OFS_FIRST_CMP:  st_nxt.dat[7:0] = st_r.cmp_buffer;
            OFS_SECOND_CMP: st_nxt.dat[7:0] = st_r.second_compare_reg;
            OFS_STATUS: begin
               st_nxt.dat[7:0]                    = lower_up_counter;
               st_nxt.dat[ST_UPPER_LSB +: 8]      = upper_up_counter;
               st_nxt.dat[ST_FLOP_BIT]            = st_r.output_toggle_flop;
            end
            default: st_nxt.dat = DATA_ZERO;
         endcase
      end
      st_nxt.pin = st_nxt.pin_en & st_nxt.output_toggle_flop;              // RULE17
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign wb_ack_o           = st_r.ack;
   assign wb_dat_o           = st_r.dat;
   assign timer_output_pin_o = st_r.pin;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   AST_PPG_TOGGLE: assert property (@(posedge clk_i) disable iff (rst_i)   // RULE1
      (st_r.pair_mode_field == PAIR_PPG) && st_r.run_lo && st_r.tog_en && lo_m1 && !lo_m2
      && !flop_wr |=> (st_r.output_toggle_flop != $past(st_r.output_toggle_flop)))
      else $error("pulse mode flop did not toggle on first compare");
   AST_PPG_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i)    // RULE2
      (st_r.pair_mode_field == PAIR_PPG) && lo_m2 |=> (lower_up_counter == CNT_RESET))
      else $error("pulse mode counter not cleared on second compare");
   AST_PPG_DBUF: assert property (@(posedge clk_i) disable iff (rst_i)     // RULE5
      (st_r.pair_mode_field == PAIR_PPG) && st_r.double_buffer_enable && lo_m2 && !wr_hit
      |=> (st_r.first_compare_reg == $past(st_r.cmp_buffer)))
      else $error("pulse mode buffer not reloaded");
   AST_PWM_UPPER: assert property (@(posedge clk_i) disable iff (rst_i)    // RULE7
      (st_r.pair_mode_field == PAIR_PWM) && st_r.run_up && up_tick && !up_m && !wr_hit
      |=> (upper_up_counter == $past(upper_up_counter) + 8'h01))
      else $error("upper timer not counting beside pwm");
   AST_PWM_TOGGLE: assert property (@(posedge clk_i) disable iff (rst_i)   // RULE8
      (st_r.pair_mode_field == PAIR_PWM) && st_r.run_lo && st_r.tog_en && ovf && !lo_m1
      && !flop_wr |=> (st_r.output_toggle_flop != $past(st_r.output_toggle_flop)))
      else $error("pwm flop did not toggle on overflow");
   AST_PWM_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i)    // RULE9
      (st_r.pair_mode_field == PAIR_PWM) && st_r.run_lo && !wr_hit
      ##0 (lower_up_counter == top) ##0 lo_tick |=> (lower_up_counter == CNT_RESET))
      else $error("pwm counter not cleared at overflow");
   AST_PWM_DBUF: assert property (@(posedge clk_i) disable iff (rst_i)     // RULE11
      (st_r.pair_mode_field == PAIR_PWM) && st_r.double_buffer_enable && ovf && !wr_hit
      |=> (st_r.first_compare_reg == $past(st_r.cmp_buffer)))
      else $error("pwm buffer not reloaded");
   AST_CASC_NOCLR: assert property (@(posedge clk_i) disable iff (rst_i)   // RULE12
      (st_r.pair_mode_field == PAIR_CASC16) && st_r.run_lo && lo_m1 && !joint && !wr_hit
      && (lower_up_counter != TOP_8BIT) |=> (lower_up_counter == $past(lower_up_counter) + 8'h01))
      else $error("cascade lower match cleared the counter");
   AST_PWM_PERIOD6: assert property (@(posedge clk_i) disable iff (rst_i)  // RULE13
      (st_r.pair_mode_field == PAIR_PWM) && (st_r.pwm_period_field == PERIOD_6BIT) && !wr_hit
      |=> (lower_up_counter <= TOP_6BIT) || ($past(lower_up_counter) > TOP_6BIT))
      else $error("6-bit pwm counter passed its top");
   AST_LO_STILL: assert property (@(posedge clk_i) disable iff (rst_i)     // RULE14
      (st_r.lower_clock_select == 2'h0) && st_r.run_lo && !ext_edge && !wr_hit
      |=> $stable(lower_up_counter))
      else $error("lower counter moved without a pin edge");
   AST_SRC_UPPER: assert property (@(posedge clk_i) disable iff (rst_i)    // RULE16
      (st_r.pair_mode_field == PAIR_DUAL8) && st_r.flop_toggle_source && !up_m && !flop_wr
      |=> $stable(st_r.output_toggle_flop))
      else $error("flop toggled by the unselected timer");
   AST_PIN: assert property (@(posedge clk_i) disable iff (rst_i)          // RULE17
      st_r.pin_en |-> (timer_output_pin_o == st_r.output_toggle_flop))
      else $error("output pin differs from flop");

endmodule

`default_nettype wire
